//--- inc/pci_pkg.sv
package pci_pkg;
	localparam int PCI_NPORT = 4;
	localparam int PCI_NPIN = 25;
	localparam int PCI_AW = 4;
	localparam int PCI_DW = 8;
	// pin index map: port a 0..7, port b 8..15, port c 16..23, port e pin 3 is 24
	localparam int PCI_PE3_IDX = 24;
	localparam logic [PCI_NPIN-1:0] PCI_ZERO = 25'h0000000;
	// register offsets
	localparam logic [PCI_AW-1:0] PCI_RISE_A = 4'h0;
	localparam logic [PCI_AW-1:0] PCI_RISE_B = 4'h1;
	localparam logic [PCI_AW-1:0] PCI_RISE_C = 4'h2;
	localparam logic [PCI_AW-1:0] PCI_RISE_E = 4'h3;
	localparam logic [PCI_AW-1:0] PCI_FALL_A = 4'h4;
	localparam logic [PCI_AW-1:0] PCI_FALL_B = 4'h5;
	localparam logic [PCI_AW-1:0] PCI_FALL_C = 4'h6;
	localparam logic [PCI_AW-1:0] PCI_FALL_E = 4'h7;
	localparam logic [PCI_AW-1:0] PCI_FLAG_A = 4'h8;
	localparam logic [PCI_AW-1:0] PCI_FLAG_B = 4'h9;
	localparam logic [PCI_AW-1:0] PCI_FLAG_C = 4'hA;
	localparam logic [PCI_AW-1:0] PCI_FLAG_E = 4'hB;
	localparam logic [PCI_AW-1:0] PCI_MASTER_EN_REG = 4'hC;
	localparam logic [PCI_AW-1:0] PCI_SUMMARY_REG = 4'hD;
	localparam logic [PCI_AW-1:0] PCI_PULLUP = 4'hE;
	// bit positions
	localparam int PCI_PE3_BIT = 3;
	localparam int PCI_MASTER_EN_BIT = 4;
	localparam int PCI_SUMMARY_BIT = 4;
	localparam int PCI_PULLUP_BIT = 3;
	localparam logic [PCI_DW-1:0] PCI_RD_ZERO = 8'h00;
	typedef enum logic [1:0] {PCI_RUN, PCI_SLEEP, PCI_WAKE} pci_pwr_e;
endpackage

//--- inc/pci_edge_if.sv
`timescale 1ns/1ns
interface pci_edge_if;
	import pci_pkg::*;
	logic [PCI_NPIN-1:0] rise_en;
	logic [PCI_NPIN-1:0] fall_en;
	logic [PCI_NPIN-1:0] edge_hit;
	modport det (input rise_en, input fall_en, output edge_hit);
	modport ctl (output rise_en, output fall_en, input edge_hit);
endinterface

//--- rtl/pci_edge_det.sv
`timescale 1ns/1ns
module pci_edge_det
	import pci_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// pins and detector results
	input wire logic [PCI_NPIN-1:0] pin_in,
	pci_edge_if.det eif
);
	logic [PCI_NPIN-1:0] sync1_q;
	logic [PCI_NPIN-1:0] sync2_q;
	logic [PCI_NPIN-1:0] prev_q;
	logic [PCI_NPIN-1:0] hit_q;

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			sync1_q <= PCI_ZERO;
			sync2_q <= PCI_ZERO;
			prev_q <= PCI_ZERO;
		end
		else
		begin
			sync1_q <= pin_in;
			sync2_q <= sync1_q;
			prev_q <= sync2_q;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < PCI_NPIN; gi++)
		begin : g_pin
			always_ff @(posedge ref_clk)
			begin
				if (!rst_n)
					hit_q[gi] <= 1'b0;
				else
					hit_q[gi] <= (eif.rise_en[gi] && sync2_q[gi] && !prev_q[gi])
						|| (eif.fall_en[gi] && !sync2_q[gi] && prev_q[gi]);
			end
		end
	endgenerate

	assign eif.edge_hit = hit_q;

	rise_hit_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(sync2_q[0] && !prev_q[0] && eif.rise_en[0]) |=> hit_q[0])
		else $error("rising edge missed");
	fall_hit_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(!sync2_q[0] && prev_q[0] && eif.fall_en[0]) |=> hit_q[0])
		else $error("falling edge missed");
	no_spurious_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(sync2_q == prev_q) |=> (hit_q == PCI_ZERO))
		else $error("edge reported without change");
endmodule

//--- rtl/pci_pin_change.sv
// Overview of operation
// - detect on ports a, b, c and e pin 3
// - any pin combination may interrupt
// - per-pin rising detector gated by rising enable
// - per-pin falling detector gated by falling enable
// - both enables detect both edge directions
// - edge sets flag; interrupt needs master enable
// - master enable off still updates flags
// - summary flag is OR of all flags
// - writing zero clears; concurrent edge wins
// - wake from sleep only with master enable
// - sleep edge flagged before wake completes
// - port e pin 3 pull-up by enable bit
// - pull-up forced for master clear or programming
`timescale 1ns/1ns
module pci_pin_change
	import pci_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// register port
	input wire logic [PCI_AW-1:0] reg_addr,
	input wire logic [PCI_DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [PCI_DW-1:0] reg_rdata,
	// pins
	input wire logic [7:0] port_a_in,
	input wire logic [7:0] port_b_in,
	input wire logic [7:0] port_c_in,
	input wire logic port_e_pin_three,
	// configuration and power
	input wire logic master_clear_pin_enable,
	input wire logic low_voltage_program_enable,
	input wire logic sleep_req,
	// outputs
	output logic pin_change_irq,
	output logic wake_req,
	output logic port_e_pin3_pullup_on
);
	pci_edge_if eif();
	logic [PCI_NPIN-1:0] pins;
	logic [PCI_NPIN-1:0] rise_q;
	logic [PCI_NPIN-1:0] fall_q;
	logic [PCI_NPIN-1:0] flag_q;
	logic [PCI_NPIN-1:0] flag_d;
	logic [PCI_NPIN-1:0] wr_mask;
	logic [PCI_NPIN-1:0] wr_val;
	logic master_en_q;
	logic pullup_en_q;
	logic summary;
	logic [PCI_DW-1:0] rd_d;
	pci_pwr_e pwr_q;

	// only the supported pins are wired to detectors
	assign pins = {port_e_pin_three, port_c_in, port_b_in, port_a_in};

	pci_edge_det u_det (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.pin_in(pins),
		.eif(eif.det)
	);
	assign eif.rise_en = rise_q;
	assign eif.fall_en = fall_q;

	// per-port byte write decode into a flat pin vector
	function automatic logic [PCI_NPIN-1:0] wr_lanes(input logic [1:0] port);
		logic [PCI_NPIN-1:0] m;
		m = PCI_ZERO;
		case (port)
			2'h0: m[7:0] = 8'hFF;
			2'h1: m[15:8] = 8'hFF;
			2'h2: m[23:16] = 8'hFF;
			default: m[PCI_PE3_IDX] = 1'b1;
		endcase
		return m;
	endfunction

	assign wr_mask = wr_lanes(reg_addr[1:0]);
	assign wr_val = {reg_wdata[PCI_PE3_BIT], reg_wdata, reg_wdata, reg_wdata};

	// edge enables, independent per pin
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			rise_q <= PCI_ZERO;
			fall_q <= PCI_ZERO;
		end
		else if (reg_wr)
		begin
			if (reg_addr >= PCI_RISE_A && reg_addr <= PCI_RISE_E)
				rise_q <= (rise_q & ~wr_mask) | (wr_val & wr_mask);
			if (reg_addr >= PCI_FALL_A && reg_addr <= PCI_FALL_E)
				fall_q <= (fall_q & ~wr_mask) | (wr_val & wr_mask);
		end
	end

	// sticky flags: writing zero clears, a new edge always wins
	always_comb
	begin
		flag_d = flag_q;
		if (reg_wr && reg_addr >= PCI_FLAG_A && reg_addr <= PCI_FLAG_E)
			flag_d = flag_q & ~(wr_mask & ~wr_val);
		flag_d = flag_d | eif.edge_hit;
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			flag_q <= PCI_ZERO;
		else
			flag_q <= flag_d;
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			master_en_q <= 1'b0;
			pullup_en_q <= 1'b0;
		end
		else if (reg_wr)
		begin
			if (reg_addr == PCI_MASTER_EN_REG)
				master_en_q <= reg_wdata[PCI_MASTER_EN_BIT];
			if (reg_addr == PCI_PULLUP)
				pullup_en_q <= reg_wdata[PCI_PULLUP_BIT];
		end
	end

	assign summary = |flag_q;

	// interrupt is gated only by the master enable
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			pin_change_irq <= 1'b0;
		else
			pin_change_irq <= master_en_q && (|flag_d);
	end

	// sleep state: wake only when master enable is set
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			pwr_q <= PCI_RUN;
			wake_req <= 1'b0;
		end
		else
		begin
			wake_req <= 1'b0;
			case (pwr_q)
				PCI_RUN:
					if (sleep_req)
						pwr_q <= PCI_SLEEP;
				PCI_SLEEP:
					if (master_en_q && (|flag_q))
					begin
						pwr_q <= PCI_WAKE;
						wake_req <= 1'b1;
					end
				PCI_WAKE:
					pwr_q <= PCI_RUN;
				default:
					pwr_q <= PCI_RUN;
			endcase
		end
	end

	// pull-up forced on for master clear or low-voltage programming
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			port_e_pin3_pullup_on <= 1'b0;
		else
			port_e_pin3_pullup_on <= pullup_en_q || low_voltage_program_enable
				|| master_clear_pin_enable;
	end

	// read mux, data one cycle after strobe
	always_comb
	begin
		rd_d = PCI_RD_ZERO;
		case (reg_addr)
			PCI_RISE_A: rd_d = rise_q[7:0];
			PCI_RISE_B: rd_d = rise_q[15:8];
			PCI_RISE_C: rd_d = rise_q[23:16];
			PCI_RISE_E: rd_d[PCI_PE3_BIT] = rise_q[PCI_PE3_IDX];
			PCI_FALL_A: rd_d = fall_q[7:0];
			PCI_FALL_B: rd_d = fall_q[15:8];
			PCI_FALL_C: rd_d = fall_q[23:16];
			PCI_FALL_E: rd_d[PCI_PE3_BIT] = fall_q[PCI_PE3_IDX];
			PCI_FLAG_A: rd_d = flag_q[7:0];
			PCI_FLAG_B: rd_d = flag_q[15:8];
			PCI_FLAG_C: rd_d = flag_q[23:16];
			PCI_FLAG_E: rd_d[PCI_PE3_BIT] = flag_q[PCI_PE3_IDX];
			PCI_MASTER_EN_REG: rd_d[PCI_MASTER_EN_BIT] = master_en_q;
			PCI_SUMMARY_REG: rd_d[PCI_SUMMARY_BIT] = summary;
			PCI_PULLUP: rd_d[PCI_PULLUP_BIT] = pullup_en_q;
			default: rd_d = PCI_RD_ZERO;
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			reg_rdata <= PCI_RD_ZERO;
		else if (reg_rd)
			reg_rdata <= rd_d;
		else
			reg_rdata <= PCI_RD_ZERO;
	end

	flag_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		eif.edge_hit[0] |=> flag_q[0])
		else $error("edge did not set flag");
	set_wins_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(eif.edge_hit[8] && reg_wr && reg_addr == PCI_FLAG_B && !reg_wdata[0]) |=> flag_q[8])
		else $error("clear beat a new edge");
	flag_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(!eif.edge_hit[16] && reg_wr && reg_addr == PCI_FLAG_C && !reg_wdata[0]) |=> !flag_q[16])
		else $error("flag not cleared by zero write");
	flag_sticky_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(flag_q[1] && !(reg_wr && reg_addr == PCI_FLAG_A)) |=> flag_q[1])
		else $error("flag dropped by itself");
	irq_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!master_en_q |=> !pin_change_irq)
		else $error("interrupt without master enable");
	irq_raise_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(master_en_q && |flag_q && $stable(master_en_q)
		&& !(reg_wr && reg_addr >= PCI_FLAG_A && reg_addr <= PCI_FLAG_E)) |=> pin_change_irq)
		else $error("interrupt missing");
	wake_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		wake_req |-> ($past(master_en_q) && $past(summary)))
		else $error("wake without enable or flag");
	pullup_force_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(low_voltage_program_enable || master_clear_pin_enable) |=> port_e_pin3_pullup_on)
		else $error("pull-up not forced");
	pullup_on_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		pullup_en_q |=> port_e_pin3_pullup_on)
		else $error("pull-up enable ignored");
	pullup_off_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(!pullup_en_q && !low_voltage_program_enable && !master_clear_pin_enable)
		|=> !port_e_pin3_pullup_on)
		else $error("pull-up on without cause");
	wake_off_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!master_en_q |=> !wake_req)
		else $error("wake without master enable");
	reset_clear_a: assert property (@(posedge ref_clk)
		!rst_n |=> (flag_q == PCI_ZERO && rise_q == PCI_ZERO && fall_q == PCI_ZERO && !master_en_q))
		else $error("reset left state behind");
	rdata_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!reg_rd |=> (reg_rdata == PCI_RD_ZERO))
		else $error("read data outside read slot");
endmodule

//--- dv/pci_pin_drv.sv
`timescale 1ns/1ns
module pci_pin_drv
	import pci_pkg::*;
(
	// clock
	input wire logic ref_clk,
	// requested pin levels
	input wire logic [PCI_NPIN-1:0] pin_req,
	// pins
	output logic [7:0] port_a_in,
	output logic [7:0] port_b_in,
	output logic [7:0] port_c_in,
	output logic port_e_pin_three
);
	// external source moves on the rising edge, in step with it, one cycle after the request
	always_ff @(posedge ref_clk)
	begin
		port_a_in <= pin_req[7:0];
		port_b_in <= pin_req[15:8];
		port_c_in <= pin_req[23:16];
		port_e_pin_three <= pin_req[PCI_PE3_IDX];
	end
endmodule

//--- dv/tb_top.sv
`timescale 1ns/1ns
module tb_top;
	import pci_pkg::*;
	logic ref_clk = 0, rst_n = 0, wr = 0, rd = 0, mc_en = 0, lv_en = 0, slp = 0;
	logic [PCI_AW-1:0] addr = 4'h0;
	logic [PCI_DW-1:0] wdata = 8'h00, rdata;
	logic [PCI_NPIN-1:0] pins = PCI_ZERO;
	logic [7:0] pa, pb, pc;
	logic pe, irq, wake, pull, seen;
	int miscompares = 0, compares = 0, cyc = 0;
	pci_pin_drv u_pci_pin_drv (.ref_clk(ref_clk), .pin_req(pins), .port_a_in(pa), .port_b_in(pb),
		.port_c_in(pc), .port_e_pin_three(pe));
	pci_pin_change u_pci_pin_change (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(addr), .reg_wdata(wdata),
		.reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .port_a_in(pa), .port_b_in(pb), .port_c_in(pc),
		.port_e_pin_three(pe), .master_clear_pin_enable(mc_en), .low_voltage_program_enable(lv_en),
		.sleep_req(slp), .pin_change_irq(irq), .wake_req(wake), .port_e_pin3_pullup_on(pull));
	always #4 ref_clk = ~ref_clk;
	task chk(input logic [7:0] s, input logic [7:0] e);
		compares++;
		if (s !== e)
		begin
			miscompares++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task wreg(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		wr <= 1;
		addr <= a;
		wdata <= d;
		@(posedge ref_clk);
		wr <= 0;
	endtask
	task rreg(input logic [3:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		rd <= 1;
		addr <= a;
		@(posedge ref_clk);
		rd <= 0;
		#1 d = rdata;
	endtask
	task rchk(input logic [3:0] a, input logic [7:0] e);
		logic [7:0] d;
		rreg(a, d);
		chk(d, e);
	endtask
	task pins_to(input logic [PCI_NPIN-1:0] v);
		@(posedge ref_clk);
		pins <= v;
		repeat (8) @(posedge ref_clk);
		#1;
	endtask
	task watch_wake(input int n);
		seen = 0;
		repeat (n)
		begin
			@(posedge ref_clk);
			#1 if (wake === 1'b1) seen = 1;
		end
	endtask
	task report_and_stop;
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			miscompares++;
			report_and_stop();
		end
	end
	initial
	begin
		repeat (6) @(posedge ref_clk);
		rst_n <= 1;
		rchk(PCI_RISE_A, 8'h00);
		rchk(PCI_FLAG_A, 8'h00);
		rchk(4'hF, 8'h00);
		$display("test reset done");
		wreg(PCI_RISE_A, 8'h01);
		wreg(PCI_FALL_B, 8'h02);
		wreg(PCI_RISE_C, 8'h04);
		wreg(PCI_FALL_C, 8'h04);
		wreg(PCI_RISE_E, 8'h08);
		pins_to(25'h1FFFFFF);
		chk(irq, 1'b0);
		rchk(PCI_FLAG_A, 8'h01);
		rchk(PCI_FLAG_B, 8'h00);
		rchk(PCI_FLAG_C, 8'h04);
		rchk(PCI_FLAG_E, 8'h08);
		rchk(PCI_SUMMARY_REG, 8'h10);
		pins_to(PCI_ZERO);
		rchk(PCI_FLAG_B, 8'h02);
		rchk(PCI_FLAG_A, 8'h01);
		$display("test edges done");
		wreg(PCI_MASTER_EN_REG, 8'h10);
		// the enable landed on the last edge of wreg, the interrupt lands on this edge
		@(posedge ref_clk);
		#1 chk(irq, 1'b1);
		// clear only the bits seen set, others kept
		wreg(PCI_FLAG_A, 8'hFE);
		rchk(PCI_FLAG_A, 8'h00);
		wreg(PCI_FLAG_B, 8'hFF);
		rchk(PCI_FLAG_B, 8'h02);
		wreg(PCI_FLAG_B, 8'h00);
		wreg(PCI_FLAG_C, 8'h00);
		wreg(PCI_FLAG_E, 8'h00);
		rchk(PCI_SUMMARY_REG, 8'h00);
		#1 chk(irq, 1'b0);
		$display("test clear done");
		wreg(PCI_MASTER_EN_REG, 8'h00);
		@(posedge ref_clk);
		slp <= 1;
		pins_to(25'h0000001);
		watch_wake(10);
		chk(seen, 1'b0);
		rchk(PCI_FLAG_A, 8'h01);
		wreg(PCI_MASTER_EN_REG, 8'h10);
		watch_wake(10);
		chk(seen, 1'b1);
		@(posedge ref_clk);
		slp <= 0;
		$display("test sleep done");
		wreg(PCI_FALL_A, 8'h01);
		wreg(PCI_RISE_B, 8'h01);
		wreg(PCI_FLAG_A, 8'h00);
		rchk(PCI_FLAG_A, 8'h00);
		// pin 0 falls, pin 8 rises; the zero write to port b meets the pin 8 detection
		@(posedge ref_clk);
		pins <= 25'h0000100;
		repeat (3) @(posedge ref_clk);
		wreg(PCI_FLAG_B, 8'h00);
		rchk(PCI_FLAG_B, 8'h01);
		rchk(PCI_FLAG_A, 8'h01);
		$display("test set wins done");
		@(posedge ref_clk);
		rst_n <= 0;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1;
		rchk(PCI_FLAG_B, 8'h00);
		rchk(PCI_FLAG_A, 8'h00);
		rchk(PCI_RISE_B, 8'h00);
		rchk(PCI_FALL_A, 8'h00);
		rchk(PCI_MASTER_EN_REG, 8'h00);
		$display("test mid reset done");
		for (int i = 0; i < 8; i++)
		begin
			@(posedge ref_clk);
			mc_en <= i[0];
			lv_en <= i[1];
			wreg(PCI_PULLUP, {4'h0, i[2], 3'h0});
			@(posedge ref_clk);
			#1 chk(pull, i[0] | i[1] | i[2]);
		end
		$display("test pullup done");
		report_and_stop();
	end
endmodule
